// ===== inc/sfelp_pkg.sv
package sfelp_pkg;

  // Opcodes for the handled commands.
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_LOCK_WRITE = 8'he5;
  localparam logic [7:0] OP_SMALL_WIPE = 8'h20;
  localparam logic [7:0] OP_BLOCK_WIPE = 8'hd8;
  localparam logic [7:0] OP_FULL_WIPE = 8'hc7;
  localparam logic [7:0] OP_SLEEP_ENTRY = 8'hb9;
  localparam logic [7:0] OP_SLEEP_EXIT = 8'hab;

  // Frame lengths in serial bits.
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_ADDR = 6'h20;
  localparam logic [5:0] BITS_LOCK = 6'h28;

  // Self-timed durations in nanoseconds; cycle counts derive from the 8 ns clock.
  localparam int CLK_PERIOD_NS = 8;
  localparam int SMALL_WIPE_TIME_NS = 4000;
  localparam int BLOCK_WIPE_TIME_NS = 8000;
  localparam int FULL_WIPE_TIME_NS = 16000;
  localparam int SLEEP_ENTER_DELAY_NS = 800;
  localparam int SLEEP_EXIT_DELAY_NS = 800;
  localparam int POWERUP_WRITE_DELAY_NS = 8000;
  localparam int SMALL_WIPE_CYC = (SMALL_WIPE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLOCK_WIPE_CYC = (BLOCK_WIPE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FULL_WIPE_CYC = (FULL_WIPE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_ENTER_CYC = (SLEEP_ENTER_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_EXIT_CYC = (SLEEP_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_WRITE_CYC =
      (POWERUP_WRITE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Geometry: 64 sectors of 16 subsectors; sector index is A21..A16.
  localparam int SECTOR_MSB = 21;
  localparam int SECTOR_LSB = 16;
  localparam int SUBSEC_LSB = 12;
  localparam int NUM_SECTORS = 64;

  // Sector lock byte layout.
  localparam int LOCK_DOWN_BIT = 1;
  localparam int LOCK_WRITE_BIT = 0;
  localparam logic [1:0] LOCK_RESET = 2'h0;

  typedef enum logic [2:0] {
    SFELP_WIPE_NONE,
    SFELP_WIPE_SMALL,
    SFELP_WIPE_BLOCK,
    SFELP_WIPE_FULL
  } sfelp_wipe_t;

  typedef enum logic [1:0] {
    SFELP_PWR_STANDBY,
    SFELP_PWR_ENTERING,
    SFELP_PWR_SLEEP,
    SFELP_PWR_EXITING
  } sfelp_pwr_t;

  // Wipe request handed to the array control side.
  typedef struct packed {
    logic valid;
    sfelp_wipe_t kind;
    logic [23:0] addr;
  } sfelp_wipe_req_t;

endpackage : sfelp_pkg

// ===== src/sfelp_core.sv
`timescale 1ns/1ps
`default_nettype none

module sfelp_core
  import sfelp_pkg::*;
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Serial link pins from the host.
  input wire logic i_spi_cs_n,
  input wire logic i_spi_clk,
  input wire logic i_serial_in_line,
  // Non-volatile guard bits from the status store.
  input wire logic [2:0] i_area_guard_bits,
  // Status and array control.
  output logic o_write_armed_flag,
  output logic o_cycle_busy_flag,
  output logic o_deep_sleep,
  output sfelp_wipe_req_t o_wipe_req
);

  // Link synchronisers; only the second stage is read by logic.
  logic [1:0] cs_sync_ff, clk_sync_ff, din_sync_ff;
  logic cs_prev_ff, clk_prev_ff;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cs_sync_ff <= 2'h3;
      clk_sync_ff <= 2'h0;
      din_sync_ff <= 2'h0;
      cs_prev_ff <= 1'b1;
      clk_prev_ff <= 1'b0;
    end else begin
      cs_sync_ff <= {cs_sync_ff[0], i_spi_cs_n};
      clk_sync_ff <= {clk_sync_ff[0], i_spi_clk};
      din_sync_ff <= {din_sync_ff[0], i_serial_in_line};
      cs_prev_ff <= cs_sync_ff[1];
      clk_prev_ff <= clk_sync_ff[1];
    end
  end

  logic cs_n, sclk_rise, cs_rise, cs_fall;
  assign cs_n = cs_sync_ff[1];
  assign sclk_rise = clk_sync_ff[1] & ~clk_prev_ff & ~cs_n;
  assign cs_rise = cs_sync_ff[1] & ~cs_prev_ff;
  assign cs_fall = ~cs_sync_ff[1] & cs_prev_ff;

  // Frame shifter: bit count saturates so overlong frames stay recognisable.
  logic [39:0] shift_ff, nxt_shift;
  logic [5:0] bitcnt_ff, nxt_bitcnt;
  logic [7:0] opcode_ff, nxt_opcode;

  always_comb begin
    nxt_shift = shift_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_opcode = opcode_ff;
    if (cs_fall) begin
      nxt_bitcnt = 6'h00;
      nxt_shift = '0;
    end else if (sclk_rise) begin
      nxt_shift = {shift_ff[38:0], din_sync_ff[1]};
      if (bitcnt_ff != 6'h3f) begin
        nxt_bitcnt = bitcnt_ff + 6'h01;
      end
      if (bitcnt_ff == BITS_OPCODE - 6'h01) begin
        nxt_opcode = {shift_ff[6:0], din_sync_ff[1]};
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      shift_ff <= '0;
      bitcnt_ff <= 6'h00;
      opcode_ff <= 8'h00;
    end else begin
      shift_ff <= nxt_shift;
      bitcnt_ff <= nxt_bitcnt;
      opcode_ff <= nxt_opcode;
    end
  end

  // Frame checks at select rise: exact bit counts only.
  logic op_ok, frame_unlock, frame_lock, frame_small, frame_block, frame_full;
  logic frame_sleep_in, frame_sleep_out;
  assign op_ok = cs_rise;
  assign frame_unlock = op_ok && bitcnt_ff == BITS_OPCODE && opcode_ff == OP_WRITE_UNLOCK;
  assign frame_lock = op_ok && bitcnt_ff == BITS_LOCK && opcode_ff == OP_LOCK_WRITE;
  assign frame_small = op_ok && bitcnt_ff == BITS_ADDR && opcode_ff == OP_SMALL_WIPE;
  assign frame_block = op_ok && bitcnt_ff == BITS_ADDR && opcode_ff == OP_BLOCK_WIPE;
  assign frame_full = op_ok && bitcnt_ff == BITS_OPCODE && opcode_ff == OP_FULL_WIPE;
  assign frame_sleep_in = op_ok && bitcnt_ff == BITS_OPCODE && opcode_ff == OP_SLEEP_ENTRY;
  assign frame_sleep_out = op_ok && bitcnt_ff == BITS_OPCODE && opcode_ff == OP_SLEEP_EXIT;

  // Guarded area: the top 2^(n-1) sectors for guard value n, as a simple map.
  function automatic logic guarded(input logic [2:0] bp, input logic [5:0] sec);
    logic [6:0] lim;
    lim = 7'h00;
    if (bp != 3'h0) begin
      lim = 7'(NUM_SECTORS) - (7'h01 << (bp - 3'h1));
    end
    guarded = (bp == 3'h7) || (bp != 3'h0 && {1'b0, sec} >= lim);
  endfunction : guarded

  // Lock store: two bits per sector, volatile.
  logic [1:0] lock_ff [NUM_SECTORS];
  logic [1:0] nxt_lock [NUM_SECTORS];

  logic [23:0] frame_addr, lock_addr;
  logic [5:0] frame_sec, lock_sec;
  assign frame_addr = shift_ff[23:0];
  assign lock_addr = shift_ff[31:8];
  assign frame_sec = frame_addr[SECTOR_MSB:SECTOR_LSB];
  assign lock_sec = lock_addr[SECTOR_MSB:SECTOR_LSB];

  // Control state.
  sfelp_pwr_t pwr_ff, nxt_pwr;
  logic armed_ff, nxt_armed;
  logic busy_ff, nxt_busy;
  logic [31:0] tmr_ff, nxt_tmr;
  logic [31:0] slp_tmr_ff, nxt_slp_tmr;
  logic [31:0] pu_ff, nxt_pu;
  sfelp_wipe_req_t req_ff, nxt_req;

  logic awake, pu_done, may_write;
  assign awake = pwr_ff == SFELP_PWR_STANDBY;
  assign pu_done = pu_ff == 32'(POWERUP_WRITE_CYC);
  assign may_write = awake && !busy_ff && pu_done;

  // Frames differ in opcode or length, so at most one of these is true at a time.
  logic take_unlock, take_lock, take_part, take_full, take_sleep_in, take_sleep_out;
  logic part_open, full_open, launch;
  assign take_unlock = frame_unlock && may_write;
  assign take_lock = frame_lock && may_write && armed_ff;
  assign take_part = (frame_small || frame_block) && may_write && armed_ff;
  assign take_full = frame_full && may_write && armed_ff;
  assign take_sleep_in = frame_sleep_in && awake && !busy_ff;
  assign take_sleep_out = frame_sleep_out && pwr_ff == SFELP_PWR_SLEEP;
  // Protected targets start no wipe, not even a busy cycle.
  assign part_open = !guarded(i_area_guard_bits, frame_sec)
      && !lock_ff[frame_sec][LOCK_WRITE_BIT];
  assign full_open = i_area_guard_bits == 3'h0;
  assign launch = (take_part && part_open) || (take_full && full_open);

  // Power-up write delay: counts once after reset, then holds.
  always_comb begin
    nxt_pu = pu_ff;
    if (!pu_done) begin
      nxt_pu = pu_ff + 32'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pu_ff <= 32'h0;
    end else begin
      pu_ff <= nxt_pu;
    end
  end

  // Lock store: volatile bits change at once, with no timed cycle.
  always_comb begin
    for (int i = 0; i < NUM_SECTORS; i++) begin
      nxt_lock[i] = lock_ff[i];
    end
    if (take_lock) begin
      nxt_lock[lock_sec] = {shift_ff[LOCK_DOWN_BIT], shift_ff[LOCK_WRITE_BIT]};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NUM_SECTORS; i++) begin
        lock_ff[i] <= LOCK_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_SECTORS; i++) begin
        lock_ff[i] <= nxt_lock[i];
      end
    end
  end

  // Armed flag: a protected wipe still uses it up, so the host must unlock again.
  always_comb begin
    nxt_armed = armed_ff;
    if (take_unlock) begin
      nxt_armed = 1'b1;
    end else if (take_lock || take_part || take_full) begin
      nxt_armed = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      armed_ff <= 1'b0;
    end else begin
      armed_ff <= nxt_armed;
    end
  end

  // Wipe cycle: busy stands for exactly the loaded count of cycles.
  always_comb begin
    nxt_busy = busy_ff;
    nxt_tmr = tmr_ff;
    if (tmr_ff != 32'h0) begin
      nxt_tmr = tmr_ff - 32'h1;
    end
    if (busy_ff && tmr_ff == 32'h1) begin
      nxt_busy = 1'b0;
    end
    if (launch) begin
      nxt_busy = 1'b1;
      if (take_full) begin
        nxt_tmr = 32'(FULL_WIPE_CYC);
      end else if (frame_small) begin
        nxt_tmr = 32'(SMALL_WIPE_CYC);
      end else begin
        nxt_tmr = 32'(BLOCK_WIPE_CYC);
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      busy_ff <= 1'b0;
      tmr_ff <= 32'h0;
    end else begin
      busy_ff <= nxt_busy;
      tmr_ff <= nxt_tmr;
    end
  end

  // Request to the array side: one pulse carrying the target of the launched wipe.
  always_comb begin
    nxt_req = req_ff;
    nxt_req.valid = 1'b0;
    if (launch && take_full) begin
      nxt_req.valid = 1'b1;
      nxt_req.kind = SFELP_WIPE_FULL;
      nxt_req.addr = 24'h000000;
    end else if (launch) begin
      nxt_req.valid = 1'b1;
      nxt_req.kind = frame_small ? SFELP_WIPE_SMALL : SFELP_WIPE_BLOCK;
      nxt_req.addr = {2'h0, frame_addr[21:0]};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      req_ff <= '0;
    end else begin
      req_ff <= nxt_req;
    end
  end

  // Power mode: its own timer, so sleep delays never disturb a wipe count.
  always_comb begin
    nxt_pwr = pwr_ff;
    nxt_slp_tmr = slp_tmr_ff;
    if (slp_tmr_ff != 32'h0) begin
      nxt_slp_tmr = slp_tmr_ff - 32'h1;
    end
    case (pwr_ff)
      SFELP_PWR_ENTERING: begin
        if (slp_tmr_ff == 32'h1) begin
          nxt_pwr = SFELP_PWR_SLEEP;
        end
      end
      SFELP_PWR_SLEEP: begin
        if (take_sleep_out) begin
          nxt_pwr = SFELP_PWR_EXITING;
          nxt_slp_tmr = 32'(SLEEP_EXIT_CYC);
        end
      end
      SFELP_PWR_EXITING: begin
        if (slp_tmr_ff == 32'h1) begin
          nxt_pwr = SFELP_PWR_STANDBY;
        end
      end
      default: begin
        // Select rise alone only deselects; sleep needs its own command.
        if (take_sleep_in) begin
          nxt_pwr = SFELP_PWR_ENTERING;
          nxt_slp_tmr = 32'(SLEEP_ENTER_CYC);
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pwr_ff <= SFELP_PWR_STANDBY;
      slp_tmr_ff <= 32'h0;
    end else begin
      pwr_ff <= nxt_pwr;
      slp_tmr_ff <= nxt_slp_tmr;
    end
  end

  assign o_write_armed_flag = armed_ff;
  assign o_cycle_busy_flag = busy_ff;
  assign o_deep_sleep = pwr_ff == SFELP_PWR_SLEEP;
  assign o_wipe_req = req_ff;

endmodule : sfelp_core

`default_nettype wire

// ===== dv/sfelp_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sfelp_core_chk
  import sfelp_pkg::*;
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Pins and status.
  input wire logic i_spi_cs_n,
  input wire logic [2:0] i_area_guard_bits,
  input wire logic o_write_armed_flag,
  input wire logic o_cycle_busy_flag,
  input wire logic o_deep_sleep,
  input wire sfelp_wipe_req_t o_wipe_req
);
  logic [11:0] busy_cnt_ff;
  logic [11:0] nxt_busy_cnt;
  // The counter holds the length of the busy run at the edge where busy is seen low.
  always_comb begin
    nxt_busy_cnt = o_cycle_busy_flag ? busy_cnt_ff + 12'h001 : 12'h000;
  end
  always_ff @(posedge i_core_clk) begin
    busy_cnt_ff <= i_sys_rst ? 12'h000 : nxt_busy_cnt;
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  a_rst_clears:
    assert property (disable iff (1'b0) $fell(i_sys_rst) |-> !o_write_armed_flag &&
      !o_cycle_busy_flag && !o_deep_sleep) else $error("flags not clear after reset");
  a_launch_flags:
    assert property (o_wipe_req.valid |-> o_cycle_busy_flag && !o_write_armed_flag)
      else $error("launch without busy or with armed flag");
  a_busy_cause:
    assert property ($rose(o_cycle_busy_flag) |-> o_wipe_req.valid)
      else $error("busy rose without launch");
  a_busy_length:
    assert property ($fell(o_cycle_busy_flag) |-> busy_cnt_ff == SMALL_WIPE_CYC ||
      busy_cnt_ff == BLOCK_WIPE_CYC || busy_cnt_ff == FULL_WIPE_CYC)
      else $error("busy run has wrong length");
  a_full_guard:
    assert property (o_wipe_req.valid && o_wipe_req.kind == SFELP_WIPE_FULL |->
      i_area_guard_bits == 3'h0) else $error("full wipe under guard");
  a_pulse_once:
    assert property (o_wipe_req.valid |=> !o_wipe_req.valid) else $error("launch not one cycle");
  a_launch_cs:
    assert property ($rose(o_cycle_busy_flag) |-> i_spi_cs_n && $past(i_spi_cs_n))
      else $error("launch while selected");
  a_sleep_idle:
    assert property (o_deep_sleep |-> !o_cycle_busy_flag) else $error("asleep while busy");
  a_arm_awake:
    assert property ($rose(o_write_armed_flag) |-> !o_deep_sleep && i_spi_cs_n)
      else $error("armed while asleep or selected");
  c_small: cover property (o_wipe_req.valid && o_wipe_req.kind == SFELP_WIPE_SMALL);
  c_sleep: cover property ($rose(o_deep_sleep));
  c_done: cover property ($fell(o_cycle_busy_flag));
endmodule : sfelp_core_chk
`default_nettype wire

// ===== dv/sfelp_host.sv
`timescale 1ns/1ps
`default_nettype none
module sfelp_host (
  // Clock.
  input wire logic i_core_clk,
  // Serial pins.
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_mosi
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
  end
  // Mode 0 frame, MSB first, 64 ns link period; the clock rests low between frames.
  task automatic frame(input logic [39:0] d, input int n);
    o_cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_mosi <= d[i];
      repeat (4) @(posedge i_core_clk);
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_core_clk);
    o_cs_n <= 1'b1;
    o_mosi <= ~o_mosi;
    // Deselect long enough to cover the sleep delays as well.
    repeat (120) @(posedge i_core_clk);
  endtask : frame
endmodule : sfelp_host
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sfelp_pkg::*;
  logic clk;
  logic rst;
  logic [2:0] guard;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic armed;
  logic busy;
  logic sleep;
  logic busy_q;
  sfelp_wipe_req_t req;
  sfelp_wipe_t kind;
  logic [23:0] waddr;
  int errors = 0;
  int checks = 0;
  int reqs = 0;
  int blen = 0;
  int cyc = 0;
  sfelp_host host (.i_core_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));
  sfelp_core DUT (.i_core_clk(clk), .i_sys_rst(rst), .i_spi_cs_n(cs_n), .i_spi_clk(sclk),
    .i_serial_in_line(mosi), .i_area_guard_bits(guard), .o_write_armed_flag(armed),
    .o_cycle_busy_flag(busy), .o_deep_sleep(sleep), .o_wipe_req(req));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic end_sim();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc <= cyc + 1;
    busy_q <= busy;
    if (req.valid) begin
      reqs <= reqs + 1;
      kind <= req.kind;
      waddr <= req.addr;
    end
    if (busy) begin
      blen <= busy_q ? blen + 1 : 1;
    end
    if (cyc == 40000) begin
      errors = errors + 1;
      end_sim();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic t_wipe(input logic u, input logic [39:0] fr, input int n,
      input logic [2:0] g, input sfelp_wipe_t ek, input logic ea, input int el);
    int r0;
    guard <= g;
    if (u) begin
      host.frame({32'h0, OP_WRITE_UNLOCK}, 8);
    end
    r0 = reqs;
    host.frame(fr, n);
    chk("armed", ea, armed);
    chk("launches", ek != SFELP_WIPE_NONE, reqs - r0);
    if (ek != SFELP_WIPE_NONE) begin
      chk("kind", ek, kind);
      chk("addr", ek == SFELP_WIPE_FULL ? 32'h0 : {10'h0, fr[21:0]}, {8'h0, waddr});
      for (int i = 0; i < 3000 && busy; i++) @(posedge clk);
      chk("busy_len", el, blen);
    end else begin
      chk("busy", 0, busy);
    end
  endtask : t_wipe
  task automatic t_early();
    host.frame({32'h0, OP_WRITE_UNLOCK}, 8);
    chk("armed", 0, armed);
    chk("busy", 0, busy);
    chk("sleep", 0, sleep);
  endtask : t_early
  task automatic t_busy();
    host.frame({32'h0, OP_WRITE_UNLOCK}, 8);
    host.frame({8'h00, OP_SMALL_WIPE, 24'h020000}, 32);
    host.frame({32'h0, OP_SLEEP_ENTRY}, 8);
    chk("busy", 1, busy);
    for (int i = 0; i < 600 && busy; i++) @(posedge clk);
    chk("busy_len", SMALL_WIPE_CYC, blen);
    chk("sleep", 0, sleep);
  endtask : t_busy
  task automatic t_lock();
    host.frame({32'h0, OP_WRITE_UNLOCK}, 8);
    host.frame({OP_LOCK_WRITE, 24'h050000, 8'h01}, 40);
    chk("armed", 0, armed);
    t_wipe(1, {8'h00, OP_SMALL_WIPE, 24'hc51000}, 32, 3'h0, SFELP_WIPE_NONE, 0, 0);
  endtask : t_lock
  task automatic t_sleep();
    host.frame({32'h0, OP_SLEEP_ENTRY}, 8);
    chk("sleep", 1, sleep);
    host.frame({32'h0, OP_WRITE_UNLOCK}, 8);
    chk("armed", 0, armed);
    host.frame({31'h0, OP_SLEEP_EXIT, 1'b0}, 9);
    chk("sleep", 1, sleep);
    host.frame({32'h0, OP_SLEEP_EXIT}, 8);
    chk("sleep", 0, sleep);
    t_wipe(1, {8'h00, OP_SMALL_WIPE, 24'h010000}, 32, 3'h0, SFELP_WIPE_SMALL, 0,
      SMALL_WIPE_CYC);
  endtask : t_sleep
  initial begin
    rst = 1'b1;
    guard = 3'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_early();
    repeat (1000) @(posedge clk);
    t_wipe(1, {8'h00, OP_SMALL_WIPE, 24'hc53000}, 32, 3'h0, SFELP_WIPE_SMALL, 0,
      SMALL_WIPE_CYC);
    t_wipe(0, {8'h00, OP_BLOCK_WIPE, 24'h020000}, 32, 3'h0, SFELP_WIPE_NONE, 0, 0);
    t_wipe(1, {9'h0, OP_SMALL_WIPE, 23'h010000}, 31, 3'h0, SFELP_WIPE_NONE, 1, 0);
    t_wipe(1, {8'h00, OP_BLOCK_WIPE, 24'h3f0000}, 32, 3'h7, SFELP_WIPE_NONE, 0, 0);
    t_wipe(1, {32'h0, OP_FULL_WIPE}, 8, 3'h1, SFELP_WIPE_NONE, 0, 0);
    t_wipe(1, {32'h0, OP_FULL_WIPE}, 8, 3'h0, SFELP_WIPE_FULL, 0, FULL_WIPE_CYC);
    t_wipe(1, {8'h00, OP_BLOCK_WIPE, 24'h000000}, 32, 3'h0, SFELP_WIPE_BLOCK, 0,
      BLOCK_WIPE_CYC);
    t_busy();
    t_lock();
    t_sleep();
    host.frame({32'h0, OP_WRITE_UNLOCK}, 8);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("armed", 0, armed);
    end_sim();
  end
endmodule : tb
bind sfelp_core sfelp_core_chk u_chk (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_spi_cs_n(i_spi_cs_n), .i_area_guard_bits(i_area_guard_bits),
  .o_write_armed_flag(o_write_armed_flag), .o_cycle_busy_flag(o_cycle_busy_flag),
  .o_deep_sleep(o_deep_sleep), .o_wipe_req(o_wipe_req));
`default_nettype wire
